// File: rtl/adcs_cfg.svh
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH
// Functional notes
// - a 10-bit conversion takes exactly 11 conversion clock periods.
// - clock select 000/100/001/101/010/110 gives 2/4/8/16/32/64 oscillator periods; x11 is RC.
// - the chosen channel is converted whatever its pin direction; driven levels get converted.
// - port data reads return zero on pins configured as analog inputs.
// - with zero acquisition time, conversion waits until after the next instruction.
// - acquisition code 010 gives four conversion clocks of acquisition, then converts.
// - clearing start/done during a conversion aborts it at once.
// - an aborted conversion leaves the result register pair untouched.
// - after completion or abort, wait two conversion clocks, then resume acquisition.
// - compare trigger with mode 1011 and converter on sets the start bit.
// - while the converter is off the compare trigger is ignored.
// - calibrate makes the next start a dummy conversion whose result cancels later offset.
// - acquisition code 000 holds conversion off one instruction cycle for sleep entry.
// - completion loads the result pair (the offset for a dummy conversion), clears start/done, sets the interrupt flag.
// - acquisition codes 000..111 give 0,2,4,6,8,12,16,20 conversion clocks.
// - justify bit set places the result right, clear places it left.
// - reset turns the converter off, aborts conversion, leaves result registers alone.

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADCS_OFS_RES_HI   8'h00
`define ADCS_OFS_RES_LO   8'h04
`define ADCS_OFS_CTRL     8'h08
`define ADCS_OFS_PINCFG   8'h0C
`define ADCS_OFS_TIMING   8'h10
`define ADCS_OFS_STATUS   8'h14
`define ADCS_OFS_PORT     8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ADCS_CTRL_ON      0
`define ADCS_CTRL_GO      1
`define ADCS_CTRL_CHS     5:2
`define ADCS_CTRL_CAL     7
`define ADCS_PIN_PCFG     3:0
`define ADCS_PIN_VREF     5:4
`define ADCS_TIM_CCS      2:0
`define ADCS_TIM_ACQ      5:3
`define ADCS_TIM_JUST     7
`define ADCS_ST_FLAG      0
`define ADCS_ST_IEN       1

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define ADCS_RST_BYTE     8'h00
`define ADCS_CMP_MODE_TRG 4'hB
`define ADCS_CONV_TADS    4'hA
`define ADCS_WAIT_TADS    2'h2
`define ADCS_PCFG_LIMIT   5'h0F
// acquisition clocks for codes 7..0, five bits each
`define ADCS_ACQ_TABLE    {5'h14, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00}
// oscillator periods per conversion clock for codes 7..0; x11 entries unused
`define ADCS_DIV_TABLE    {7'h00, 7'h40, 7'h10, 7'h04, 7'h00, 7'h20, 7'h08, 7'h02}
`define ADCS_SAR_MSB      10'h200

`endif

// File: rtl/adcs_clkgen.sv
`timescale 1ns/100ps
`include "adcs_cfg.svh"
module adcs_clkgen (
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    input  wire logic   rc_clk_in,
    adcs_tick_if.gen    tk
);
    adcs_pkg::adcs_gen_t s_q;
    adcs_pkg::adcs_gen_t s_d;
    logic [6:0]          div;
    logic [55:0]         div_tbl;

    assign div_tbl = `ADCS_DIV_TABLE;
    assign div     = div_tbl[tk.clk_sel*7 +: 7];
    assign tk.tick = s_q.tick;

    always_comb begin
        s_d         = s_q;
        s_d.rc_meta = rc_clk_in;
        s_d.rc_sync = s_q.rc_meta;
        s_d.rc_prev = s_q.rc_sync;
        s_d.tick    = 1'b0;
        if (!tk.run) begin
            s_d.cnt = 7'h00;
        end else if (tk.clk_sel[1:0] == 2'b11) begin
            // rc source: one pulse per synchronised rising edge
            s_d.tick = s_q.rc_sync & ~s_q.rc_prev;
            s_d.cnt  = 7'h00;
        end else if (s_q.cnt >= div - 7'h01) begin
            s_d.tick = 1'b1;
            s_d.cnt  = 7'h00;
        end else begin
            s_d.cnt  = s_q.cnt + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : adcs_clkgen

// File: rtl/adcs_pkg.sv
package adcs_pkg;

    typedef enum logic [2:0] {
        ADCS_OFF     = 3'b000,
        ADCS_SAMPLE  = 3'b001,
        ADCS_HOLDOFF = 3'b010,
        ADCS_ACQ     = 3'b011,
        ADCS_CONV    = 3'b100,
        ADCS_WAIT    = 3'b101
    } adcs_state_t;

    typedef struct packed {
        logic        rc_meta;
        logic        rc_sync;
        logic        rc_prev;
        logic [6:0]  cnt;
        logic        tick;
    } adcs_gen_t;

    typedef struct packed {
        adcs_state_t st;
        logic [7:0]  ctrl;
        logic [7:0]  pincfg;
        logic [7:0]  timing;
        logic        flag;
        logic        ien;
        logic [7:0]  res_hi;
        logic [7:0]  res_lo;
        logic [9:0]  trial;
        logic [9:0]  offset;
        logic        cal_run;
        logic [4:0]  tcnt;
        logic [7:0]  hcnt;
        logic [7:0]  pin_meta;
        logic [7:0]  pin_sync;
        logic [31:0] prdata;
        logic        pslverr;
    } adcs_regs_t;

endpackage : adcs_pkg

// File: rtl/adcs_tick_if.sv
`timescale 1ns/100ps
interface adcs_tick_if;
    logic [2:0] clk_sel;
    logic       run;
    logic       tick;

    modport gen  (input clk_sel, input run, output tick);
    modport user (output clk_sel, output run, input tick);
endinterface : adcs_tick_if

// File: rtl/adcs_top.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "adcs_cfg.svh"
module adcs_top #(
    parameter int        NPINS       = 8,
    parameter logic [7:0] INSTR_CLKS = 8'h04
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // clock sources and compare trigger
    input  wire logic              rc_clk_in,
    input  wire logic              cmp_trigger,
    input  wire logic [3:0]        compare_mode_field,
    // analog core
    output logic                   core_sample,
    output logic                   core_convert,
    output logic                   core_cal,
    output logic [3:0]             channel_select,
    output logic [1:0]             vref_config,
    output logic [9:0]             core_trial,
    input  wire logic              comp_in,
    // port pins and status
    input  wire logic [NPINS-1:0]  pin_in,
    output logic                   conv_irq_flag,
    output logic                   conv_irq_enable
);
    adcs_pkg::adcs_regs_t s_q;
    adcs_pkg::adcs_regs_t s_d;
    adcs_tick_if          tk ();
    logic                 wr;
    logic                 setup;
    logic                 tick;
    logic [9:0]           raw;
    logic [9:0]           fixed;
    logic [39:0]          acq_tbl;
    logic [NPINS-1:0]     port_view;
    logic                 go_set;
    logic                 go_clr;
    logic                 done;
    logic                 abort;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [9:0] comp_offset(input logic [9:0] r, input logic [9:0] o);
        comp_offset = (r > o) ? r - o : 10'h000;
    endfunction : comp_offset

    function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
        justify = right ? {6'h00, r} : {r, 6'h00};
    endfunction : justify

    function automatic logic [NPINS-1:0] analog_mask(input logic [3:0] pcfg);
        logic [NPINS-1:0] m;
        m = '0;
        // pin i is analog while pcfg + i stays below the limit
        for (int i = 0; i < NPINS; i++) begin
            m[i] = ({1'b0, pcfg} + 5'(i)) < `ADCS_PCFG_LIMIT;
        end
        analog_mask = m;
    endfunction : analog_mask

    // ---------------------------------------------------------------
    // conversion clock
    // ---------------------------------------------------------------
    assign tk.clk_sel = s_q.timing[`ADCS_TIM_CCS];
    assign tk.run     = s_q.ctrl[`ADCS_CTRL_ON];
    assign tick       = tk.tick;

    adcs_clkgen u_clkgen (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .rc_clk_in (rc_clk_in),
        .tk        (tk.gen)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    assign wr      = psel & penable & pwrite;
    assign setup   = psel & ~penable;
    assign pready  = 1'b1;
    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign acq_tbl = `ADCS_ACQ_TABLE;

    // the converter sees only the channel select, never the pin direction
    assign channel_select  = s_q.cal_run ? 4'h0 : s_q.ctrl[`ADCS_CTRL_CHS];
    assign vref_config     = s_q.pincfg[`ADCS_PIN_VREF];
    assign core_trial      = s_q.trial;
    assign core_cal        = s_q.cal_run;
    assign core_sample     = (s_q.st == adcs_pkg::ADCS_SAMPLE) | (s_q.st == adcs_pkg::ADCS_ACQ)
                           | (s_q.st == adcs_pkg::ADCS_HOLDOFF);
    assign core_convert    = (s_q.st == adcs_pkg::ADCS_CONV);
    assign conv_irq_flag   = s_q.flag;
    assign conv_irq_enable = s_q.ien;

    assign port_view = s_q.pin_sync & ~analog_mask(s_q.pincfg[`ADCS_PIN_PCFG]);

    // last bit decision folded into the final trial word
    assign raw   = comp_in ? s_q.trial : (s_q.trial & ~10'h001);
    assign fixed = comp_offset(raw, s_q.offset);

    // start requests: software set only once already on, trigger only while on
    assign go_set = (wr && paddr == `ADCS_OFS_CTRL && pwdata[`ADCS_CTRL_GO]
                     && s_q.ctrl[`ADCS_CTRL_ON] && pwdata[`ADCS_CTRL_ON])
                  | (cmp_trigger && compare_mode_field == `ADCS_CMP_MODE_TRG
                     && s_q.ctrl[`ADCS_CTRL_ON]);
    assign go_clr = wr && paddr == `ADCS_OFS_CTRL && !pwdata[`ADCS_CTRL_GO];
    assign done   = (s_q.st == adcs_pkg::ADCS_CONV) && tick && (s_q.tcnt == 5'(`ADCS_CONV_TADS));
    assign abort  = go_clr && !go_set && ((s_q.st == adcs_pkg::ADCS_CONV)
                    || (s_q.st == adcs_pkg::ADCS_ACQ) || (s_q.st == adcs_pkg::ADCS_HOLDOFF));

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.pin_meta = 8'(pin_in);
        s_d.pin_sync = s_q.pin_meta;
        s_d.pslverr  = 1'b0;

        // register reads are captured in the setup cycle
        if (setup && !pwrite) begin
            s_d.prdata = 32'h0000_0000;
            case (paddr)
                `ADCS_OFS_RES_HI: s_d.prdata = {24'h000000, s_q.res_hi};
                `ADCS_OFS_RES_LO: s_d.prdata = {24'h000000, s_q.res_lo};
                `ADCS_OFS_CTRL:   s_d.prdata = {24'h000000, s_q.ctrl & 8'hBF};
                `ADCS_OFS_PINCFG: s_d.prdata = {24'h000000, s_q.pincfg & 8'h3F};
                `ADCS_OFS_TIMING: s_d.prdata = {24'h000000, s_q.timing & 8'hBF};
                `ADCS_OFS_STATUS: s_d.prdata = {30'h00000000, s_q.ien, s_q.flag};
                `ADCS_OFS_PORT:   s_d.prdata = {24'h000000, 8'(port_view)};
                default:          s_d.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            case (paddr)
                `ADCS_OFS_RES_HI, `ADCS_OFS_RES_LO, `ADCS_OFS_CTRL, `ADCS_OFS_PINCFG,
                `ADCS_OFS_TIMING, `ADCS_OFS_STATUS, `ADCS_OFS_PORT: s_d.pslverr = 1'b0;
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // register writes
        if (wr) begin
            case (paddr)
                `ADCS_OFS_RES_HI: s_d.res_hi = pwdata[7:0];
                `ADCS_OFS_RES_LO: s_d.res_lo = pwdata[7:0];
                `ADCS_OFS_CTRL: begin
                    s_d.ctrl = {pwdata[7], 1'b0, pwdata[5:0]};
                    // go is owned by the sequencer below
                    s_d.ctrl[`ADCS_CTRL_GO] = s_q.ctrl[`ADCS_CTRL_GO];
                end
                `ADCS_OFS_PINCFG: s_d.pincfg = {2'b00, pwdata[5:0]};
                `ADCS_OFS_TIMING: s_d.timing = {pwdata[7], 1'b0, pwdata[5:0]};
                `ADCS_OFS_STATUS: s_d.ien    = pwdata[`ADCS_ST_IEN];
                default: ;
            endcase
        end

        // flag: write one clears, a completion in the same cycle wins
        s_d.flag = (s_q.flag & ~(wr && paddr == `ADCS_OFS_STATUS && pwdata[`ADCS_ST_FLAG])) | done;

        // start/done bit
        if (go_set) begin
            s_d.ctrl[`ADCS_CTRL_GO] = 1'b1;
        end else if (go_clr || done) begin
            s_d.ctrl[`ADCS_CTRL_GO] = 1'b0;
        end

        // sequencer
        case (s_q.st)
            adcs_pkg::ADCS_OFF: begin
                if (s_q.ctrl[`ADCS_CTRL_ON]) begin
                    s_d.st = adcs_pkg::ADCS_SAMPLE;
                end
            end
            adcs_pkg::ADCS_SAMPLE: begin
                if (s_q.ctrl[`ADCS_CTRL_GO]) begin
                    s_d.tcnt    = 5'h00;
                    s_d.hcnt    = 8'h00;
                    s_d.cal_run = s_q.ctrl[`ADCS_CTRL_CAL];
                    s_d.st      = (s_q.timing[`ADCS_TIM_ACQ] == 3'b000)
                                ? adcs_pkg::ADCS_HOLDOFF : adcs_pkg::ADCS_ACQ;
                end
            end
            adcs_pkg::ADCS_HOLDOFF: begin
                // one instruction cycle passes before the first conversion clock
                if (s_q.hcnt < INSTR_CLKS) begin
                    s_d.hcnt = s_q.hcnt + 8'h01;
                end else if (tick) begin
                    s_d.st    = adcs_pkg::ADCS_CONV;
                    s_d.trial = `ADCS_SAR_MSB;
                    s_d.tcnt  = 5'h00;
                end
            end
            adcs_pkg::ADCS_ACQ: begin
                if (tick) begin
                    if (s_q.tcnt + 5'h01 >= acq_tbl[s_q.timing[`ADCS_TIM_ACQ]*5 +: 5]) begin
                        s_d.st    = adcs_pkg::ADCS_CONV;
                        s_d.trial = `ADCS_SAR_MSB;
                        s_d.tcnt  = 5'h00;
                    end else begin
                        s_d.tcnt = s_q.tcnt + 5'h01;
                    end
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (tick) begin
                    if (s_q.tcnt == 5'(`ADCS_CONV_TADS)) begin
                        // eleventh conversion clock ends the conversion
                        s_d.st   = adcs_pkg::ADCS_WAIT;
                        s_d.tcnt = 5'h00;
                        if (s_q.cal_run) begin
                            s_d.offset  = s_q.trial;
                            s_d.cal_run = 1'b0;
                            s_d.ctrl[`ADCS_CTRL_CAL] = 1'b0;
                        end else begin
                            {s_d.res_hi, s_d.res_lo} = justify(comp_offset(s_q.trial, s_q.offset),
                                                               s_q.timing[`ADCS_TIM_JUST]);
                        end
                    end else begin
                        s_d.tcnt = s_q.tcnt + 5'h01;
                        if (s_q.tcnt < 5'(`ADCS_CONV_TADS)) begin
                            // keep or drop the bit under test, then try the next one
                            s_d.trial = (comp_in ? s_q.trial : (s_q.trial & ~(`ADCS_SAR_MSB >> s_q.tcnt)))
                                      | (`ADCS_SAR_MSB >> (s_q.tcnt + 5'h01));
                        end
                    end
                end
            end
            adcs_pkg::ADCS_WAIT: begin
                if (tick) begin
                    if (s_q.tcnt + 5'h01 >= 5'(`ADCS_WAIT_TADS)) begin
                        s_d.st = adcs_pkg::ADCS_SAMPLE;
                    end
                    s_d.tcnt = s_q.tcnt + 5'h01;
                end
            end
            default: s_d.st = adcs_pkg::ADCS_OFF;
        endcase

        // abort keeps the result pair as it was
        if (abort) begin
            s_d.st      = adcs_pkg::ADCS_WAIT;
            s_d.tcnt    = 5'h00;
            s_d.cal_run = 1'b0;
        end
        if (!s_q.ctrl[`ADCS_CTRL_ON]) begin
            s_d.st                  = adcs_pkg::ADCS_OFF;
            s_d.cal_run             = 1'b0;
            s_d.ctrl[`ADCS_CTRL_GO] = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // result pair and offset survive reset on purpose
            s_q.st       <= adcs_pkg::ADCS_OFF;
            s_q.ctrl     <= `ADCS_RST_BYTE;
            s_q.pincfg   <= `ADCS_RST_BYTE;
            s_q.timing   <= `ADCS_RST_BYTE;
            s_q.flag     <= 1'b0;
            s_q.ien      <= 1'b0;
            s_q.trial    <= 10'h000;
            s_q.cal_run  <= 1'b0;
            s_q.tcnt     <= 5'h00;
            s_q.hcnt     <= 8'h00;
            s_q.pin_meta <= 8'h00;
            s_q.pin_sync <= 8'h00;
            s_q.prdata   <= 32'h0000_0000;
            s_q.pslverr  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    logic unused_raw;
    assign unused_raw = ^fixed;
endmodule : adcs_top

// File: verification/adc_conversion_sequencer_tb.sv
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
    typedef struct packed {logic [31:0] v; logic [31:0] m;} adcs_exp_t;
    localparam logic [9:0]  CAL = 10'h005;
    localparam logic [31:0] M   = 32'h800000FF;
    logic        core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        rc_clk_in = 1'b0, cmp_trigger = 1'b0;
    logic        pready, pslverr, core_sample, core_convert, core_cal, comp_in, conv_irq_flag, conv_irq_enable;
    logic [1:0]  vref_config;
    logic [7:0]  paddr = 8'h00, pin_in = 8'h00, eh, el;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  compare_mode_field = 4'h0, channel_select;
    logic [9:0]  core_trial, r, level = 10'h000;
    logic [2:0]  ccs_l [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int          dv_l [8] = '{2, 4, 8, 16, 32, 64, 0, 0};
    int          seed = 32'h014A34C0, n_fail = 0, check_count = 0, len = 0, i;
    adcs_exp_t   rq[$], cq[$];
    always #5 core_clk = ~core_clk;
    always #37 rc_clk_in = ~rc_clk_in;
    adcs_top #(.INSTR_CLKS(8'h01)) u_adcs_top (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .rc_clk_in, .cmp_trigger, .compare_mode_field, .core_sample, .core_convert,
        .core_cal, .channel_select, .vref_config, .core_trial, .comp_in, .pin_in, .conv_irq_flag,
        .conv_irq_enable);
    adcs_core_model #(.CAL_LVL(CAL)) u_adcs_core_model (.core_clk, .core_convert, .core_cal, .core_trial,
        .level, .comp_in);
    // --------
    // helpers
    // --------
    task automatic chk(input logic [31:0] got, input adcs_exp_t e, input string s);
        check_count++;
        if ((got & e.m) !== (e.v & e.m)) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, e.v);
        end
    endtask : chk
    // one idle edge first so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        rq.push_back(adcs_exp_t'{v, m});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse;
        cmp_trigger <= 1'b1;
        @(posedge core_clk);
        cmp_trigger <= 1'b0;
    endtask : pulse
    task automatic wait_sample;
        while (core_sample !== 1'b1) @(posedge core_clk);
    endtask : wait_sample
    task automatic conv(input logic [7:0] tim, input logic [7:0] ctl, input logic [31:0] dv, input logic trig);
        level <= 10'($random(seed));
        wr(8'h10, tim);
        wait_sample();
        cq.push_back(adcs_exp_t'{11 * dv, (dv != 0) ? 32'hFFFFFFFF : 32'h0});
        if (trig) pulse();
        else wr(8'h08, ctl);
        while (conv_irq_flag !== 1'b1) @(posedge core_clk);
        chk({28'h0, channel_select}, adcs_exp_t'{{28'h0, ctl[5:2]}, 32'hF}, "channel");
        r = (level > CAL) ? level - CAL : 10'h000;
        eh = tim[7] ? {6'h00, r[9:8]} : r[9:2];
        el = tim[7] ? r[7:0] : {r[1:0], 6'h00};
        rd(8'h00, {24'h0, eh}, M);
        rd(8'h04, {24'h0, el}, M);
        rd(8'h08, {24'h0, ctl & 8'hFD}, M);
        wr(8'h14, 8'h01);
        rd(8'h14, 32'h0, 32'h80000001);
    endtask : conv
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // --------
    // result watcher
    // --------
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) chk({pslverr, prdata[30:0]}, rq.pop_front(), "read");
        if (core_convert === 1'b1) len++;
        else if (len != 0) begin
            chk(len, cq.pop_front(), "conversion length");
            len = 0;
        end
    end
    // --------
    // tests
    // --------
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        pin_in <= 8'($random(seed));
        for (i = 8; i <= 20; i += 4) rd(8'(i), 32'h0, M);
        rd(8'h1C, 32'h80000000, 32'hFFFFFFFF);
        wr(8'h0C, 8'h1C);
        rd(8'h18, {24'h0, pin_in & 8'hF8}, M);
        chk({30'h0, vref_config}, adcs_exp_t'{32'h1, 32'h3}, "vref");
        $display("test registers done");
        wr(8'h00, 8'h5A);
        wr(8'h04, 8'hA5);
        wr(8'h08, 8'h01);
        wr(8'h10, 8'h10);
        wait_sample();
        cq.push_back(adcs_exp_t'{32'h16, 32'hFFFFFFFF});
        wr(8'h08, 8'h83);
        while (core_cal !== 1'b1) @(posedge core_clk);
        while (core_cal !== 1'b0) @(posedge core_clk);
        rd(8'h00, 32'h5A, M);
        rd(8'h04, 32'hA5, M);
        rd(8'h08, 32'h01, 32'h80000083);
        // the dummy conversion also raises the flag; clear it before real conversions
        wr(8'h14, 8'h01);
        $display("test calibration done");
        for (i = 0; i < 8; i++) conv({i[0], 1'b0, i[2:0], ccs_l[i]}, {2'b00, 4'(i), 2'b11}, 32'(dv_l[i]), 1'b0);
        $display("test conversions done");
        wr(8'h10, 8'h38);
        wait_sample();
        cq.push_back(adcs_exp_t'{32'h0, 32'h0});
        wr(8'h08, 8'h03);
        while (core_convert !== 1'b1) @(posedge core_clk);
        wr(8'h08, 8'h01);
        wait_sample();
        rd(8'h00, {24'h0, eh}, M);
        rd(8'h04, {24'h0, el}, M);
        rd(8'h14, 32'h0, 32'h80000001);
        $display("test abort done");
        wr(8'h08, 8'h00);
        compare_mode_field <= 4'hB;
        pulse();
        rd(8'h08, 32'h0, M);
        wr(8'h08, 8'h01);
        compare_mode_field <= 4'h3;
        pulse();
        rd(8'h08, 32'h01, M);
        compare_mode_field <= 4'hB;
        conv(8'h90, 8'h01, 32'h2, 1'b1);
        wr(8'h14, 8'h02);
        rd(8'h14, 32'h2, 32'h80000003);
        chk({31'h0, conv_irq_enable}, adcs_exp_t'{32'h1, 32'h1}, "irq enable");
        $display("test trigger done");
        wrap_up();
    end
    // limit well above the longest expected run
    initial begin
        #900000;
        n_fail++;
        $display("mismatch at %0t: timeout", $time);
        wrap_up();
    end
endmodule : adc_conversion_sequencer_tb

// File: verification/adcs_core_model.sv
`timescale 1ns/100ps
// --------
// analog core stand-in
// --------
module adcs_core_model #(
    parameter logic [9:0] CAL_LVL = 10'h005
) (
    input wire logic       core_clk,
    input wire logic       core_convert,
    input wire logic       core_cal,
    input wire logic [9:0] core_trial,
    input wire logic [9:0] level,
    output logic           comp_in
);
    logic flip_q = 1'b0;
    // comparator output is junk outside a conversion
    always @(posedge core_clk) flip_q <= ~flip_q;
    // dummy conversion sees only the internal offset
    assign comp_in = !core_convert ? flip_q : (core_trial <= (core_cal ? CAL_LVL : level));
endmodule : adcs_core_model

// File: verification/adcs_sva.sv
`timescale 1ns/100ps
// --------
// sequencer port checks
// --------
module adcs_sva (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        core_sample,
    input wire logic        core_convert,
    input wire logic        core_cal,
    input wire logic [3:0]  channel_select,
    input wire logic        conv_irq_flag
);
    logic [9:0]  len_q;
    logic [3:0]  pcfg_q;
    logic [15:0] amask;
    logic        wr_ctl;
    logic        wr_clr;
    assign wr_ctl = psel && penable && pwrite && paddr == 8'h08;
    assign wr_clr = psel && penable && pwrite && paddr == 8'h14 && pwdata[0];
    // pins below 15 - pcfg are analog
    assign amask = (16'h0001 << (4'hF - pcfg_q)) - 16'h0001;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            len_q  <= 10'h000;
            pcfg_q <= 4'h0;
        end else begin
            len_q <= core_convert ? len_q + 10'h001 : 10'h000;
            if (psel && penable && pwrite && paddr == 8'h0C) begin
                pcfg_q <= pwdata[3:0];
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    AST_FLAG_AT_END: assert property ($rose(conv_irq_flag) |-> $fell(core_convert))
        else $error("flag rose without a conversion ending");
    AST_FLAG_STICKY: assert property ($fell(conv_irq_flag) |-> $past(wr_clr))
        else $error("flag dropped without a clear write");
    AST_WAIT_GAP: assert property ($rose(conv_irq_flag) |-> !core_sample [*4])
        else $error("sampling resumed too early");
    AST_ACQ_BEFORE: assert property ($rose(core_convert) |-> $past(core_sample) && $past(core_sample, 2))
        else $error("conversion began without prior sampling");
    AST_EXCL: assert property (!(core_sample && core_convert))
        else $error("sampling and converting at once");
    AST_CAL_CHAN: assert property (core_cal && core_convert |-> channel_select == 4'h0)
        else $error("calibration touched an input channel");
    AST_CONV_LEN: assert property ($fell(core_convert) && !$past(wr_ctl) |-> len_q >= 10'h016)
        else $error("conversion ended too soon");
    AST_PORT_ANALOG: assert property (psel && !penable && !pwrite && paddr == 8'h18 |=>
        (prdata[7:0] & amask[7:0]) == 8'h00)
        else $error("analog pin read as nonzero");
    COV_CONV: cover property ($rose(core_convert));
    COV_CAL: cover property (core_cal && core_convert);
    COV_DONE: cover property ($rose(conv_irq_flag));
endmodule : adcs_sva

bind adcs_top adcs_sva u_adcs_sva (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .core_sample, .core_convert, .core_cal, .channel_select, .conv_irq_flag);
